// [logic/urx_map.vh]
`ifndef URX_MAP_VH
`define URX_MAP_VH
// register byte offsets on the avalon bus (own layout, see note)
`define URX_OFF_CTRL     8'h98
`define URX_OFF_BUF      8'h99
`define URX_OFF_PWR      8'h87
`define URX_OFF_OWNADDR  8'hA9
`define URX_OFF_ADDRMASK 8'hB9
// serial control bit positions
`define URX_CTL_MODE_HI  7
`define URX_CTL_MODE_LO  6
`define URX_CTL_MPEN     5
`define URX_CTL_RXEN     4
`define URX_CTL_TX9      3
`define URX_CTL_RX9      2
`define URX_CTL_DONE     0
// power control bit position
`define URX_PWR_FESEL    6
// reset values
`define URX_RST_BYTE     8'h00
// fifo depth and width
`define URX_FIFO_DEPTH   8
`define URX_FIFO_AW      3
`define URX_FIFO_W       10
`endif

// [logic/urx_fifo.v]
`timescale 1ns/1ps
// small synchronous fifo holding received frames
module urx_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,   // system clock
  input  wire             rst_b,     // async reset, active low
  input  wire             in_valid,  // write request
  output wire             in_ready,  // space available
  input  wire [WIDTH-1:0] in_data,   // write word
  output wire             out_valid, // word available
  input  wire             out_ready, // consumer takes word
  output wire [WIDTH-1:0] out_data   // head word
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage
  reg [AW-1:0]    wp_reg;              // write pointer
  reg [AW-1:0]    rp_reg;              // read pointer
  reg [AW:0]      cnt_reg;             // fill count
  wire            push;                // accepted write
  wire            pop;                 // accepted read
  assign in_ready  = (cnt_reg != DEPTH);
  assign out_valid = (cnt_reg != 0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // storage write, no reset needed
  always @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
  // pointers and count
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// [logic/urx_qual.v]
`timescale 1ns/1ps
`include "urx_map.vh"
module urx_qual (
  input  wire        sys_clk,          // 25 MHz system clock
  input  wire        rst_b,            // async reset, active low
  input  wire [7:0]  avs_address,      // avalon byte address
  input  wire        avs_read,         // avalon read
  input  wire        avs_write,        // avalon write
  input  wire [31:0] avs_writedata,    // avalon write data
  input  wire [3:0]  avs_byteenable,   // avalon byte enables
  output reg  [31:0] avs_readdata,     // avalon read data
  output wire        avs_waitrequest,  // avalon wait
  output reg         avs_response_err, // unmapped access marker
  input  wire        frame_valid,      // deframer has a frame
  output wire        frame_ready,      // fifo can take a frame
  input  wire [7:0]  frame_data,       // received data byte
  input  wire        frame_ninth,      // ninth bit (11-bit modes)
  input  wire        frame_stop,       // sampled stop bit level
  output wire [1:0]  uart_mode,        // current mode to deframer
  output wire        rx_enable,        // receive enable to deframer
  output wire        receive_done_flag // receive done, level
);
  reg  [7:0] own_slave_address_reg;  // own address
  reg  [7:0] slave_address_mask_reg; // address mask
  reg  [7:0] serial_control_reg;     // control, bit7 mode high
  reg  [7:0] power_control_reg;      // power control
  reg        framing_error_flag_reg; // sticky framing flag
  reg  [7:0] serial_buffer_reg;      // received byte
  reg        ack_reg;                // one-cycle bus answer
  wire       fifo_valid;             // frame at fifo head
  wire [9:0] fifo_data;              // head: stop, ninth, data
  wire [7:0] hd_data;                // head data byte
  wire       hd_ninth;               // head ninth bit
  wire       hd_stop;                // head stop bit
  wire       async_mode;             // modes 1..3
  wire       eleven_bit;             // modes 2, 3
  wire       mp_en;                  // multiproc active
  wire       marker;                 // address marker bit
  wire [7:0] given_addr;             // given address
  wire [7:0] bcast_addr;             // broadcast address
  wire       given_hit;              // given match
  wire       bcast_hit;              // broadcast match
  wire       qualify;                // frame may load
  wire       load;                   // load buffer now
  wire       frame_err;              // stop bit missing
  wire       take;                   // pop head frame
  wire       fesel;                  // framing flag view
  wire       wr;                     // bus write accepted
  wire       rd;                     // bus read accepted
  wire       ctl_wr;                 // control write, byte 0
  wire       done_clr;               // software clears done
  wire       done_set;               // hardware sets done

  urx_fifo #(
    .WIDTH(`URX_FIFO_W),
    .DEPTH(`URX_FIFO_DEPTH),
    .AW   (`URX_FIFO_AW)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .in_valid (frame_valid),
    .in_ready (frame_ready),
    .in_data  ({frame_stop, frame_ninth, frame_data}),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data (fifo_data)
  );

  assign hd_data  = fifo_data[7:0];
  assign hd_ninth = fifo_data[8];
  assign hd_stop  = fifo_data[9];

  // mode decode; mode high bit never altered by the flag view
  assign uart_mode  = {serial_control_reg[`URX_CTL_MODE_HI], serial_control_reg[`URX_CTL_MODE_LO]};
  assign rx_enable  = serial_control_reg[`URX_CTL_RXEN];
  assign async_mode = (uart_mode != 2'h0);
  assign eleven_bit = uart_mode[1];
  assign fesel      = power_control_reg[`URX_PWR_FESEL];
  // multiproc ignored in shift mode
  assign mp_en      = serial_control_reg[`URX_CTL_MPEN] & async_mode;
  // ninth bit marks address in 11-bit, stop bit in 10-bit
  assign marker     = eleven_bit ? hd_ninth : hd_stop;

  // address filter
  assign given_addr = own_slave_address_reg & slave_address_mask_reg;
  assign bcast_addr = own_slave_address_reg | slave_address_mask_reg;
  // positions where mask zero are ignored; reset gives all ignored
  assign given_hit  = ((hd_data & slave_address_mask_reg) == given_addr);
  // zero bits of broadcast are ignored
  assign bcast_hit  = ((hd_data & bcast_addr) == bcast_addr);
  // in 10-bit mode the stop bit must also be valid
  assign qualify    = ~mp_en | (marker & (given_hit | bcast_hit) & (eleven_bit | hd_stop));

  // a frame is consumed once done is clear, else it waits in the fifo
  assign take      = fifo_valid & ~serial_control_reg[`URX_CTL_DONE];
  assign load      = take & qualify;
  assign frame_err = take & async_mode & ~hd_stop;

  // avalon slave: single-cycle wait, answer on second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr      = avs_write & ack_reg;
  assign rd      = avs_read & ack_reg;
  assign ctl_wr  = wr & (avs_address == `URX_OFF_CTRL) & avs_byteenable[0];
  assign done_clr = ctl_wr & ~avs_writedata[`URX_CTL_DONE];
  assign done_set = load;
  assign receive_done_flag = serial_control_reg[`URX_CTL_DONE];

  // answer strobe, drops after one cycle
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // register writes and hardware updates
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      own_slave_address_reg  <= `URX_RST_BYTE;
      slave_address_mask_reg <= `URX_RST_BYTE;
      serial_control_reg     <= `URX_RST_BYTE;
      power_control_reg      <= `URX_RST_BYTE;
      framing_error_flag_reg <= 1'b0;
      serial_buffer_reg      <= `URX_RST_BYTE;
    end else begin
      if (wr & avs_byteenable[0]) begin
        case (avs_address)
          `URX_OFF_OWNADDR: begin
            own_slave_address_reg <= avs_writedata[7:0];
          end
          `URX_OFF_ADDRMASK: begin
            slave_address_mask_reg <= avs_writedata[7:0];
          end
          `URX_OFF_PWR: begin
            power_control_reg <= avs_writedata[7:0];
          end
          default: begin
          end
        endcase
      end
      // control: bit7 goes to mode or framing flag view
      if (ctl_wr) begin
        serial_control_reg[6:1] <= avs_writedata[6:1];
        if (!fesel) begin
          serial_control_reg[`URX_CTL_MODE_HI] <= avs_writedata[7];
        end
      end
      // done flag: set wins over clear
      if (done_set) begin
        serial_control_reg[`URX_CTL_DONE] <= 1'b1;
      end else if (done_clr) begin
        serial_control_reg[`URX_CTL_DONE] <= 1'b0;
      end
      // load buffer and ninth bit (stop bit in 10-bit mode)
      if (load) begin
        serial_buffer_reg <= hd_data;
        serial_control_reg[`URX_CTL_RX9] <= eleven_bit ? hd_ninth : hd_stop;
      end
      // sticky framing flag, set wins over software clear
      if (frame_err) begin
        framing_error_flag_reg <= 1'b1;
      end else if (ctl_wr & fesel & ~avs_writedata[7]) begin
        framing_error_flag_reg <= 1'b0;
      end
    end
  end

  // read mux and unmapped marker, loaded in the wait cycle so the data
  // stand at the edge where waitrequest is seen low
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata     <= 32'h00000000;
      avs_response_err <= 1'b0;
    end else begin
      avs_response_err <= 1'b0;
      if ((avs_read | avs_write) & ~ack_reg) begin
        avs_readdata <= 32'h00000000;
        case (avs_address)
          `URX_OFF_CTRL: begin
            avs_readdata[7:0] <= {(fesel ? framing_error_flag_reg : serial_control_reg[7]),
                                  serial_control_reg[6:0]};
          end
          `URX_OFF_BUF: begin
            avs_readdata[7:0] <= serial_buffer_reg;
          end
          `URX_OFF_PWR: begin
            avs_readdata[7:0] <= power_control_reg;
          end
          `URX_OFF_OWNADDR: begin
            avs_readdata[7:0] <= own_slave_address_reg;
          end
          `URX_OFF_ADDRMASK: begin
            avs_readdata[7:0] <= slave_address_mask_reg;
          end
          default: begin
            avs_response_err <= 1'b1; // unmapped reads zero
          end
        endcase
      end
    end
  end
endmodule

// [sim/urx_qual_sva.sv]
`timescale 1ns/1ps
// bus handshake, done flag and mode checks at the block ports
module urx_qual_sva (
  input wire        sys_clk,           // clock
  input wire        rst_b,             // reset, active low
  input wire [7:0]  avs_address,       // bus address
  input wire        avs_read,          // bus read
  input wire        avs_write,         // bus write
  input wire [31:0] avs_writedata,     // bus write data
  input wire [31:0] avs_readdata,      // bus read data
  input wire        avs_waitrequest,   // bus wait
  input wire        avs_response_err,  // unmapped marker
  input wire [1:0]  uart_mode,         // mode bits
  input wire        receive_done_flag  // done level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // accepted access, control write, control write clearing done, unmapped
  wire acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire cw  = acc & avs_write & (avs_address == 8'h98);
  wire cw0 = cw & ~avs_writedata[0];
  wire um  = !(avs_address inside {8'h98, 8'h99, 8'h87, 8'hA9, 8'hB9});
  sequence s_req; $rose(avs_read | avs_write); endsequence
  sequence s_ans; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_wait; s_req |-> s_ans; endproperty
  property p_idle; !(avs_read | avs_write) |-> !avs_waitrequest; endproperty
  property p_hold; receive_done_flag && !cw |=> receive_done_flag; endproperty
  property p_fall; $fell(receive_done_flag) |-> $past(cw0); endproperty
  property p_mode; !$stable(uart_mode) |-> $past(cw); endproperty
  property p_lo; cw |=> uart_mode[0] == $past(avs_writedata[6]); endproperty
  property p_err; acc |-> avs_response_err == um; endproperty
  property p_rd; acc && avs_read |=> avs_readdata[31:8] == 24'h000000; endproperty
  a_wait: assert property (p_wait) else $error("wait cycle count wrong");
  a_idle: assert property (p_idle) else $error("wait without request");
  a_hold: assert property (p_hold) else $error("done dropped by itself");
  a_fall: assert property (p_fall) else $error("done cleared without write");
  a_mode: assert property (p_mode) else $error("mode changed without write");
  a_lo: assert property (p_lo) else $error("mode low bit not written");
  a_err: assert property (p_err) else $error("unmapped marker wrong");
  a_rd: assert property (p_rd) else $error("read data upper bits set");
endmodule
bind urx_qual urx_qual_sva u_sva (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .uart_mode(uart_mode),
  .receive_done_flag(receive_done_flag));

// [sim/urx_far_end.sv]
`timescale 1ns/1ps
// remote sender: offers one deframed frame at a time
module urx_far_end (
  input  wire       sys_clk,     // clock
  input  wire       frame_ready, // block can take a frame
  output reg        frame_valid, // frame offered
  output reg  [7:0] frame_data,  // data byte
  output reg        frame_ninth, // ninth bit
  output reg        frame_stop   // stop bit level
);
  // idle lines start low
  initial begin
    frame_valid = 1'b0;
    frame_data = 8'h00;
    frame_ninth = 1'b0;
    frame_stop = 1'b0;
  end
  // hold the offer until ready is seen, then scramble the released lines
  task send(input [7:0] d, input n, input s);
    @(posedge sys_clk);
    {frame_valid, frame_data, frame_ninth, frame_stop} <= {1'b1, d, n, s};
    @(posedge sys_clk);
    while (frame_ready !== 1'b1) @(posedge sys_clk);
    {frame_valid, frame_data, frame_ninth, frame_stop} <= {1'b0, ~d, ~n, ~s};
  endtask
endmodule

// [sim/test_urx_qual.sv]
`timescale 1ns/1ps
// register, qualification and buffering tests
module test_urx_qual;
  reg         sys_clk = 1'b0;          // clock
  reg         rst_b = 1'b0;            // reset, active low
  reg  [7:0]  avs_address = 8'h00;     // bus address
  reg         avs_read = 1'b0;         // bus read
  reg         avs_write = 1'b0;        // bus write
  reg  [31:0] avs_writedata = 32'h0;   // bus write data
  wire [31:0] avs_readdata;            // bus read data
  wire        avs_waitrequest, fv, fr, f9, fs, done; // handshake and frame lines
  wire [7:0]  fd;                      // frame byte
  wire [1:0]  uart_mode;               // mode bits
  integer     err_count = 0;           // mismatches
  integer     cmp_count = 0;           // comparisons
  integer     i;                       // loop index
  reg  [31:0] q;                       // last read value
  always #20 sys_clk = ~sys_clk;
  urx_qual DUT (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(),
    .frame_valid(fv), .frame_ready(fr), .frame_data(fd), .frame_ninth(f9), .frame_stop(fs),
    .uart_mode(uart_mode), .rx_enable(), .receive_done_flag(done));
  urx_far_end FAR (.sys_clk(sys_clk), .frame_ready(fr), .frame_valid(fv), .frame_data(fd),
    .frame_ninth(f9), .frame_stop(fs));
  // compare and count
  task chk(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // print counts and verdict, end the run
  task close_out;
    $display("counts cmp=%0d err=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one bus access, held until wait is seen low at a rising edge; data taken there
  task bus(input w, input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, 24'h0, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask
  // one frame from the far side, then let it settle
  task frm(input [7:0] d, input n, input s);
    FAR.send(d, n, s);
    repeat (3) @(posedge sys_clk);
  endtask
  task t_reset;
    bus(0, 8'hA9, 8'h00); chk(q, 0);
    bus(0, 8'hB9, 8'h00); chk(q, 0);
    bus(0, 8'h20, 8'h00);
    $display("reset test done");
  endtask
  task t_mpx;
    bus(1, 8'h98, 8'hB0);
    frm(8'h11, 0, 1); chk(done, 0);
    frm(8'h55, 1, 1); chk(done, 1);
    bus(0, 8'h99, 8'h00); chk(q, 8'h55);
    bus(0, 8'h98, 8'h00); chk(q, 8'hB5);
    bus(1, 8'h98, 8'h90);
    frm(8'h22, 0, 1); chk(done, 1);
    $display("multiprocessor test done");
  endtask
  task t_shift;
    bus(1, 8'h98, 8'h30);
    bus(1, 8'h87, 8'h40);
    frm(8'hA5, 0, 0); chk(done, 1);
    bus(0, 8'h98, 8'h00); chk(q & 8'h80, 0);
    $display("shift mode test done");
  endtask
  task t_filter;
    bus(1, 8'hA9, 8'hC0);
    bus(1, 8'hB9, 8'hFD);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 8'h98, 8'h70);
      frm(32'hC0FFC1C2 >> (i * 8), 0, 1); chk(done, (4'b1101 >> i) & 1);
    end
    bus(1, 8'h98, 8'h70);
    frm(8'hC0, 0, 0); chk(done, 0);
    bus(0, 8'h98, 8'h00); chk(q & 8'h80, 8'h80);
    frm(8'hC0, 0, 1); bus(0, 8'h98, 8'h00); chk(q & 8'h80, 8'h80);
    bus(1, 8'h98, 8'h70); bus(0, 8'h98, 8'h00); chk(q & 8'h80, 0);
    chk(uart_mode, 1);
    $display("address filter test done");
  endtask
  task t_fill;
    bus(1, 8'hA9, 8'h00);
    bus(1, 8'hB9, 8'h00);
    bus(1, 8'h98, 8'h10);
    for (i = 0; i < 9; i = i + 1) FAR.send(i, 0, 1);
    repeat (2) @(posedge sys_clk);
    chk(fr, 0);
    for (i = 0; i < 9; i = i + 1) begin
      bus(0, 8'h99, 8'h00); chk(q, i);
      bus(1, 8'h98, 8'h10);
      repeat (3) @(posedge sys_clk);
    end
    chk(done, 0);
    $display("buffer test done");
  endtask
  // watchdog against a hung handshake
  initial begin
    #(40 * 30000);
    err_count = err_count + 1;
    close_out;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_mpx;
    t_shift;
    t_filter;
    t_fill;
    close_out;
  end
endmodule
